// >>> logic/cmp_ctrl.sv
// What this block does
// (RL1) reference select bit high routes internal reference to non-inverting input, else pin.
// (RL2) result visible in own control register and in shared mirror bit.
// (RL3) pin drives result only when output-enable, enable set and direction bit clear.
// (RL4) output-enable overrides port data latch; enable bit alone does not.
// (RL5) internal result registered once per instruction cycle; pin result not latched.
// (RL6) polarity bit inverts the comparator decision.
// (RL7) two-bit channel field picks one of four shared negative inputs.
// (RL8) top bit of control register enables the comparator.
// (RL9) control register read captures current result into first mismatch latch.
// (RL10) second latch samples result each first phase; xor of latches is mismatch.
// (RL11) mismatch lasts until control read or result returns to earlier level.
// (RL12) control register write also clears the mismatch.
// (RL13) change flag set on rising edge of mismatch, not its level.
// (RL14) after clearing latches, return to earlier level raises new change.
// (RL15) change detection independent of output-enable bit.
// (RL16) change flag sticky until software writes zero; writing one sets it.
// (RL17) request needs change, peripheral and global enables; flag sets regardless.
// (RL18) change during a control read may be missed; here it never is.
// (RL19) enabled comparator runs in sleep; change plus two enables wakes device.
// (RL20) reset returns control and shared registers to reset values; comparators off, shared aux field resets to 2.
// (RL21) bit 3 reads zero, result bit read-only, other fields read-write reset zero.
// (RL22) software waits about 1 us after enabling before clearing and enabling.
// (RL23) mirror bits 7 and 6 read-only; reading them leaves mismatch latches alone.
// (RL24) analog decision is asynchronous, synchronised then taken through first-phase latch.
// (RL25) each comparator has own mismatch and flag; access clears only its own.
`timescale 1ns/1ps
`default_nettype none

module cmp_ctrl #(
    parameter int NUM_CMP = cmp_ctrl_pkg::NUM_CMP
) (
    // clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rst_n,
    // register port
    input  wire logic [cmp_ctrl_pkg::ADDR_W-1:0]   addr,
    input  wire logic [cmp_ctrl_pkg::DATA_W-1:0]   wdata,
    input  wire logic                              wr_stb,
    input  wire logic                              rd_stb,
    output logic      [cmp_ctrl_pkg::DATA_W-1:0]   rdata,
    // analog cores
    input  wire logic [NUM_CMP-1:0]                cmp_raw,
    output logic      [NUM_CMP-1:0]                cmp_enable_bit,
    output logic      [NUM_CMP-1:0]                cmp_ref_select,
    output logic      [2*NUM_CMP-1:0]              cmp_neg_channel_sel,
    output logic      [1:0]                        shared_ref_cfg,
    output logic      [1:0]                        shared_aux_cfg,
    // port pins
    input  wire logic [NUM_CMP-1:0]                port_direction_bit,
    output logic      [NUM_CMP-1:0]                pin_out,
    output logic      [NUM_CMP-1:0]                pin_oe,
    output logic      [NUM_CMP-1:0]                pin_override,
    // system
    output logic                                   irq_req,
    output logic                                   wake_req
);

    // ***************************************************************
    // instruction cycle phase
    // ***************************************************************
    cmp_ctrl_pkg::phase_t phase_r;
    logic                 phase_one_en;

    // four clocks make one instruction cycle; phase_one_en is its one-cycle enable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase_r <= cmp_ctrl_pkg::PH_ONE;
        end else begin
            case (phase_r)
                cmp_ctrl_pkg::PH_ONE:   phase_r <= cmp_ctrl_pkg::PH_TWO;
                cmp_ctrl_pkg::PH_TWO:   phase_r <= cmp_ctrl_pkg::PH_THREE;
                cmp_ctrl_pkg::PH_THREE: phase_r <= cmp_ctrl_pkg::PH_FOUR;
                cmp_ctrl_pkg::PH_FOUR:  phase_r <= cmp_ctrl_pkg::PH_ONE;
                default:                phase_r <= cmp_ctrl_pkg::PH_ONE;
            endcase
        end
    end

    assign phase_one_en = (phase_r == cmp_ctrl_pkg::PH_ONE);

    // ***************************************************************
    // decode
    // ***************************************************************
    // one decode serves both the capture strobe and the field writes
    function automatic logic ctrl_hit(input logic [cmp_ctrl_pkg::ADDR_W-1:0] a,
                                      input int idx);
        ctrl_hit = (idx == 0) ? (a == cmp_ctrl_pkg::OFF_CTRL_ONE)
                              : (a == cmp_ctrl_pkg::OFF_CTRL_TWO);
    endfunction

    // ***************************************************************
    // shared, enable and interrupt control registers
    // ***************************************************************
    logic [1:0]         shared_ref_r;
    logic [1:0]         shared_aux_r;
    logic [NUM_CMP-1:0] change_irq_en_r;
    logic               peripheral_irq_en_r;
    logic               global_irq_en_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            shared_ref_r <= cmp_ctrl_pkg::SHARED_CFG_RST;  // see (RL20)
            shared_aux_r <= cmp_ctrl_pkg::AUX_CFG_RST;
        end else if (wr_stb && addr == cmp_ctrl_pkg::OFF_SHARED) begin
            shared_ref_r <= wdata[cmp_ctrl_pkg::SHARED_CFG_MSB:cmp_ctrl_pkg::SHARED_CFG_LSB];
            shared_aux_r <= wdata[cmp_ctrl_pkg::AUX_CFG_MSB:cmp_ctrl_pkg::AUX_CFG_LSB];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            change_irq_en_r <= '0;
        end else if (wr_stb && addr == cmp_ctrl_pkg::OFF_FLAGS) begin
            change_irq_en_r <= wdata[cmp_ctrl_pkg::IRQ_EN_LSB +: NUM_CMP];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            peripheral_irq_en_r <= 1'b0;
            global_irq_en_r     <= 1'b0;
        end else if (wr_stb && addr == cmp_ctrl_pkg::OFF_IRQ_CTRL) begin
            peripheral_irq_en_r <= wdata[cmp_ctrl_pkg::PERIPH_BIT];
            global_irq_en_r     <= wdata[cmp_ctrl_pkg::GLOBAL_BIT];
        end
    end

    assign shared_ref_cfg = shared_ref_r;
    assign shared_aux_cfg = shared_aux_r;

    // ***************************************************************
    // per-comparator logic
    // ***************************************************************
    logic [NUM_CMP-1:0] en_r;
    logic [NUM_CMP-1:0] oe_r;
    logic [NUM_CMP-1:0] inv_r;
    logic [NUM_CMP-1:0] ref_r;
    logic [1:0]         ch_r [NUM_CMP];
    logic [NUM_CMP-1:0] sync1_r;
    logic [NUM_CMP-1:0] sync2_r;
    logic [NUM_CMP-1:0] result_r;
    logic [NUM_CMP-1:0] capture_r;
    logic [NUM_CMP-1:0] mismatch;
    logic [NUM_CMP-1:0] mismatch_d_r;
    logic [NUM_CMP-1:0] flag_r;
    logic [NUM_CMP-1:0] ctrl_access;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            assign ctrl_access[gi] = (rd_stb || wr_stb) && ctrl_hit(addr, gi);

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    en_r[gi]  <= cmp_ctrl_pkg::CTRL_RST[cmp_ctrl_pkg::EN_BIT];  // see (RL20)
                    oe_r[gi]  <= cmp_ctrl_pkg::CTRL_RST[cmp_ctrl_pkg::OE_BIT];
                    inv_r[gi] <= cmp_ctrl_pkg::CTRL_RST[cmp_ctrl_pkg::INV_BIT];
                    ref_r[gi] <= cmp_ctrl_pkg::CTRL_RST[cmp_ctrl_pkg::REF_BIT];
                    ch_r[gi]  <= cmp_ctrl_pkg::CTRL_RST[cmp_ctrl_pkg::CH_MSB:cmp_ctrl_pkg::CH_LSB];
                end else if (wr_stb && ctrl_hit(addr, gi)) begin
                    en_r[gi]  <= wdata[cmp_ctrl_pkg::EN_BIT];  // see (RL8)
                    oe_r[gi]  <= wdata[cmp_ctrl_pkg::OE_BIT];
                    inv_r[gi] <= wdata[cmp_ctrl_pkg::INV_BIT];
                    ref_r[gi] <= wdata[cmp_ctrl_pkg::REF_BIT];  // see (RL1)
                    ch_r[gi]  <= wdata[cmp_ctrl_pkg::CH_MSB:cmp_ctrl_pkg::CH_LSB];  // see (RL7)
                end
            end

            // first flop feeds only the second
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= cmp_raw[gi];  // see (RL24)
                    sync2_r[gi] <= sync1_r[gi];
                end
            end

            // a disabled core reads as low; it keeps running in sleep
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    result_r[gi] <= 1'b0;
                end else if (phase_one_en) begin
                    result_r[gi] <= en_r[gi] & (sync2_r[gi] ^ inv_r[gi]);  // see (RL5) (RL6) (RL10) (RL19)
                end
            end

            // write also captures: every write begins with a read
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    capture_r[gi] <= 1'b0;
                end else if (ctrl_access[gi]) begin
                    capture_r[gi] <= result_r[gi];  // see (RL9) (RL12) (RL25)
                end
            end

            assign mismatch[gi] = capture_r[gi] ^ result_r[gi];  // see (RL10) (RL11) (RL14) (RL15)

            // delayed copy: the flag follows the edge of the mismatch, not its level
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    mismatch_d_r[gi] <= 1'b0;
                end else begin
                    mismatch_d_r[gi] <= mismatch[gi];
                end
            end

            // edge set wins over a software clear in the same cycle
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    flag_r[gi] <= 1'b0;
                end else if (mismatch[gi] && !mismatch_d_r[gi]) begin
                    flag_r[gi] <= 1'b1;  // see (RL13) (RL18)
                end else if (wr_stb && addr == cmp_ctrl_pkg::OFF_FLAGS) begin
                    flag_r[gi] <= wdata[cmp_ctrl_pkg::FLAG_LSB + gi];  // see (RL16)
                end
            end

            // pin path bypasses the instruction-cycle latch
            assign pin_out[gi]      = en_r[gi] & (sync2_r[gi] ^ inv_r[gi]);  // see (RL5)
            assign pin_oe[gi]       = oe_r[gi] & en_r[gi] & ~port_direction_bit[gi];  // see (RL3)
            assign pin_override[gi] = oe_r[gi];  // see (RL4)
            assign cmp_neg_channel_sel[2*gi +: 2] = ch_r[gi];
        end
    endgenerate

    assign cmp_enable_bit = en_r;
    assign cmp_ref_select = ref_r;

    // wake needs no global enable: the core resumes, the routine runs only if allowed
    assign irq_req  = (|(flag_r & change_irq_en_r)) & peripheral_irq_en_r
                      & global_irq_en_r;  // see (RL17)
    assign wake_req = (|(flag_r & change_irq_en_r)) & peripheral_irq_en_r;  // see (RL19)

    // ***************************************************************
    // read path
    // ***************************************************************
    // bit 3 and the result bit never come from the write path, so they ignore writes
    function automatic logic [cmp_ctrl_pkg::DATA_W-1:0] ctrl_word(input int i);
        logic [cmp_ctrl_pkg::DATA_W-1:0] w;
        w = '0;  // see (RL21)
        w[cmp_ctrl_pkg::EN_BIT]     = en_r[i];
        w[cmp_ctrl_pkg::RESULT_BIT] = result_r[i];  // see (RL2)
        w[cmp_ctrl_pkg::OE_BIT]     = oe_r[i];
        w[cmp_ctrl_pkg::INV_BIT]    = inv_r[i];
        w[cmp_ctrl_pkg::REF_BIT]    = ref_r[i];
        w[cmp_ctrl_pkg::CH_MSB:cmp_ctrl_pkg::CH_LSB] = ch_r[i];
        ctrl_word = w;
    endfunction

    logic [cmp_ctrl_pkg::DATA_W-1:0] rdata_nxt;

    always_comb begin
        rdata_nxt = '0;
        case (addr)
            cmp_ctrl_pkg::OFF_CTRL_ONE: rdata_nxt = ctrl_word(0);
            cmp_ctrl_pkg::OFF_CTRL_TWO: rdata_nxt = ctrl_word(1);
            cmp_ctrl_pkg::OFF_SHARED: begin
                rdata_nxt[cmp_ctrl_pkg::MIRROR_ONE_BIT] = result_r[0];  // see (RL2) (RL23)
                rdata_nxt[cmp_ctrl_pkg::MIRROR_TWO_BIT] = result_r[1];
                rdata_nxt[cmp_ctrl_pkg::SHARED_CFG_MSB:cmp_ctrl_pkg::SHARED_CFG_LSB] = shared_ref_r;
                rdata_nxt[cmp_ctrl_pkg::AUX_CFG_MSB:cmp_ctrl_pkg::AUX_CFG_LSB] = shared_aux_r;
            end
            cmp_ctrl_pkg::OFF_FLAGS: begin
                rdata_nxt[cmp_ctrl_pkg::FLAG_LSB +: NUM_CMP]   = flag_r;
                rdata_nxt[cmp_ctrl_pkg::IRQ_EN_LSB +: NUM_CMP] = change_irq_en_r;
            end
            cmp_ctrl_pkg::OFF_IRQ_CTRL: begin
                rdata_nxt[cmp_ctrl_pkg::PERIPH_BIT] = peripheral_irq_en_r;
                rdata_nxt[cmp_ctrl_pkg::GLOBAL_BIT] = global_irq_en_r;
            end
            default: rdata_nxt = '0;
        endcase
    end

    // data held only for the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd_stb) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= '0;
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_flag_on_edge: assert property ($rose(mismatch[0]) |=> flag_r[0])  // see (RL13)
        else $error("change flag missed a mismatch edge");

    a_access_clears_mism: assert property (  // see (RL9) (RL12)
        (ctrl_access[0] && !phase_one_en) |=> !mismatch[0])
        else $error("control access left mismatch standing");

    a_other_cmp_kept: assert property (  // see (RL25)
        (ctrl_access[0] && !ctrl_access[1]) |=> $stable(capture_r[1]))
        else $error("access disturbed the other comparator latch");

    a_mirror_no_touch: assert property (  // see (RL23)
        (rd_stb && addr == cmp_ctrl_pkg::OFF_SHARED) |=> $stable(capture_r))
        else $error("mirror read changed a mismatch latch");

    a_flag_sticky: assert property (  // see (RL16)
        (flag_r[0] && !(wr_stb && addr == cmp_ctrl_pkg::OFF_FLAGS)) |=> flag_r[0])
        else $error("change flag dropped without a write");

    a_result_rate: assert property (!$stable(result_r[0]) |-> $past(phase_one_en))  // see (RL5)
        else $error("internal result moved outside the first phase");

    a_ctrl_read_word: assert property (  // see (RL21) (RL2)
        (rd_stb && ctrl_hit(addr, 0)) |=>
        (rdata[cmp_ctrl_pkg::UNUSED_BIT] == 1'b0 &&
         rdata[cmp_ctrl_pkg::RESULT_BIT] == $past(result_r[0])))
        else $error("control read word wrong");

    a_irq_gating: assert property (  // see (RL17)
        irq_req |-> (global_irq_en_r && peripheral_irq_en_r && |(flag_r & change_irq_en_r)))
        else $error("request without all enables");

    a_pin_gate: assert property (  // see (RL3)
        pin_oe[1] |-> (oe_r[1] && en_r[1] && !port_direction_bit[1]))
        else $error("pin driven without all three conditions");

    a_wake_cause: assert property (  // see (RL19)
        $rose(wake_req) |-> (peripheral_irq_en_r && |(flag_r & change_irq_en_r)))
        else $error("wake without enabled change");

    a_mism_holds: assert property (  // see (RL11)
        (mismatch[0] && !ctrl_access[0] && !phase_one_en) |=> mismatch[0])
        else $error("mismatch dropped without an access or a return");

    a_capture_own: assert property (  // see (RL9)
        ctrl_access[1] |=> capture_r[1] == $past(result_r[1]))
        else $error("access did not capture the current result");

    a_flag_write_one: assert property (  // see (RL16)
        (wr_stb && addr == cmp_ctrl_pkg::OFF_FLAGS && wdata[cmp_ctrl_pkg::FLAG_LSB])
        |=> flag_r[0])
        else $error("written one did not set the change flag");

    a_flag_cause: assert property (  // see (RL13)
        $rose(flag_r[1]) |->
        $past(mismatch[1] || (wr_stb && addr == cmp_ctrl_pkg::OFF_FLAGS)))
        else $error("change flag rose without an edge or a write");

    a_flag_any_enable: assert property ($rose(mismatch[1]) |=> flag_r[1])  // see (RL17)
        else $error("change flag missed an edge on comparator two");

    a_off_reads_low: assert property (  // see (RL8)
        (phase_one_en && !en_r[1]) |=> !result_r[1])
        else $error("disabled comparator reported a high result");

    a_phase_period: assert property (  // see (RL5)
        phase_one_en |=> (!phase_one_en)[*3] ##1 phase_one_en)
        else $error("first phase not once every four clocks");

    // ***************************************************************
    // cover points
    // ***************************************************************
    // the main scenarios that the bench walks through
    c_flag_rise:   cover property ($rose(flag_r[0]));
    c_mirror_read: cover property (rd_stb && addr == cmp_ctrl_pkg::OFF_SHARED);
    c_irq_raised:  cover property ($rose(irq_req));
    c_wake_raised: cover property ($rose(wake_req));
    c_return_edge: cover property ($fell(mismatch[1]) ##[1:40] $rose(mismatch[1]));

endmodule

`default_nettype wire

// >>> logic/cmp_ctrl_pkg.sv
`default_nettype none

package cmp_ctrl_pkg;

    // ***************************************************************
    // bus geometry
    // ***************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int NUM_CMP = 2;

    // ***************************************************************
    // register offsets
    // ***************************************************************
    localparam logic [ADDR_W-1:0] OFF_CTRL_ONE  = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_CTRL_TWO  = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_SHARED    = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_FLAGS     = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CTRL  = 3'h4;

    // ***************************************************************
    // per-comparator control register fields
    // ***************************************************************
    localparam int EN_BIT     = 7;
    localparam int RESULT_BIT = 6;
    localparam int OE_BIT     = 5;
    localparam int INV_BIT    = 4;
    localparam int UNUSED_BIT = 3;
    localparam int REF_BIT    = 2;
    localparam int CH_MSB     = 1;
    localparam int CH_LSB     = 0;
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;

    // ***************************************************************
    // shared register fields
    // ***************************************************************
    localparam int MIRROR_ONE_BIT = 7;
    localparam int MIRROR_TWO_BIT = 6;
    localparam int SHARED_CFG_MSB = 5;
    localparam int SHARED_CFG_LSB = 4;
    localparam int AUX_CFG_MSB    = 1;
    localparam int AUX_CFG_LSB    = 0;
    localparam logic [1:0] SHARED_CFG_RST = 2'h0;
    localparam logic [1:0] AUX_CFG_RST    = 2'h2;

    // ***************************************************************
    // flag, enable and interrupt control fields
    // ***************************************************************
    localparam int FLAG_LSB   = 0;
    localparam int IRQ_EN_LSB = 2;
    localparam int GLOBAL_BIT = 0;
    localparam int PERIPH_BIT = 1;

    // ***************************************************************
    // instruction cycle phases
    // ***************************************************************
    typedef enum logic [1:0] {
        PH_ONE   = 2'b00,
        PH_TWO   = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR  = 2'b11
    } phase_t;

endpackage

`default_nettype wire

// >>> testbench/cmp_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

module cmp_analog_model (
    // selects from the control registers
    input  wire logic [1:0]  cmp_enable_bit,
    input  wire logic [1:0]  cmp_ref_select,
    input  wire logic [3:0]  cmp_neg_channel_sel,
    // analog levels as eight-bit codes
    input  wire logic [15:0] pos_lvl,
    input  wire logic [31:0] neg_lvl,
    input  wire logic [7:0]  vref_lvl,
    // decisions
    output logic      [1:0]  cmp_raw
);
    // ********************
    // comparator cores
    // ********************
    logic [7:0] vplus  [2];
    logic [7:0] vminus [2];

    // a core that is switched off draws no current and reads low
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            vplus[i]   = cmp_ref_select[i] ? vref_lvl : pos_lvl[8*i +: 8];
            vminus[i]  = neg_lvl[8*cmp_neg_channel_sel[2*i +: 2] +: 8];
            cmp_raw[i] = cmp_enable_bit[i] & (vplus[i] > vminus[i]);
        end
    end
endmodule

`default_nettype wire

// >>> testbench/tb_dual_comparator_control_irq.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dual_comparator_control_irq;
    // ********************
    // signals
    // ********************
    localparam logic [2:0] AC1 = cmp_ctrl_pkg::OFF_CTRL_ONE;
    localparam logic [2:0] ASH = cmp_ctrl_pkg::OFF_SHARED;
    localparam logic [2:0] AFL = cmp_ctrl_pkg::OFF_FLAGS;
    localparam logic [2:0] AIR = cmp_ctrl_pkg::OFF_IRQ_CTRL;
    localparam int         CYCLE_LIMIT = 20000;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [7:0]  rdata;
    logic [1:0]  cmp_raw;
    logic [1:0]  cmp_enable_bit;
    logic [1:0]  cmp_ref_select;
    logic [3:0]  cmp_neg_channel_sel;
    logic [1:0]  dir = 2'h3;
    logic [1:0]  sh_ref;
    logic [1:0]  sh_aux;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe;
    logic [1:0]  pin_override;
    logic        irq_req;
    logic        wake_req;
    logic [15:0] pos_lvl = 16'h0;
    logic [31:0] neg_lvl = 32'h0;
    logic [7:0]  vref_lvl = 8'h0;
    int          errors = 0;
    int          checked = 0;
    int          cycles = 0;

    cmp_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cmp_raw(cmp_raw),
        .cmp_enable_bit(cmp_enable_bit), .cmp_ref_select(cmp_ref_select),
        .cmp_neg_channel_sel(cmp_neg_channel_sel), .shared_ref_cfg(sh_ref),
        .shared_aux_cfg(sh_aux), .port_direction_bit(dir), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_override(pin_override), .irq_req(irq_req),
        .wake_req(wake_req));

    cmp_analog_model u_model (.cmp_enable_bit(cmp_enable_bit),
        .cmp_ref_select(cmp_ref_select), .cmp_neg_channel_sel(cmp_neg_channel_sel),
        .pos_lvl(pos_lvl), .neg_lvl(neg_lvl), .vref_lvl(vref_lvl), .cmp_raw(cmp_raw));

    always #4 mclk = ~mclk;

    // ********************
    // shared tasks
    // ********************
    task automatic end_of_test();
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        chk(name, rdata, exp);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            chk("cycle limit", 8'h01, 8'h00);
            end_of_test();
        end
    end

    // ********************
    // scenarios
    // ********************
    task automatic test_reset();
        rd_chk("ctrl one", AC1, 8'h00);
        rd_chk("ctrl two", AC1 + 3'h1, 8'h00);
        rd_chk("shared", ASH, 8'h02);
        rd_chk("flags", AFL, 8'h00);
        rd_chk("irq ctrl", AIR, 8'h00);
        chk("enables", {6'h0, cmp_enable_bit}, 8'h00);
        chk("shared cfg", {4'h0, sh_ref, sh_aux}, 8'h02);
    endtask

    task automatic test_fields();
        dir <= 2'h0;
        reg_wr(AC1, 8'h7f);
        reg_wr(3'h5, 8'hff);
        rd_chk("ctrl one fields", AC1, 8'h37);
        rd_chk("unmapped", 3'h5, 8'h00);
        chk("ref select", {6'h0, cmp_ref_select}, 8'h01);
        chk("override", {6'h0, pin_override}, 8'h01);
        chk("pin drive off", {6'h0, pin_oe}, 8'h00);
        reg_wr(ASH, 8'hfd);
        rd_chk("shared fields", ASH, 8'h31);
        chk("shared cfg out", {4'h0, sh_ref, sh_aux}, 8'h0d);
        reg_wr(ASH, 8'hc2);
        rd_chk("shared restore", ASH, 8'h02);
    endtask

    task automatic test_channels();
        pos_lvl <= 16'h8000;
        for (int c = 0; c < 4; c++) begin
            neg_lvl <= 32'hc0c0c0c0 & ~(32'h80 << (8 * c));
            reg_wr(AC1 + 3'h1, 8'h80 | 8'(c));
            wait_cyc(10);
            rd_chk("channel", AC1 + 3'h1, 8'hc0 | 8'(c));
            rd_chk("mirror two", ASH, 8'h42);
        end
        neg_lvl <= 32'h40404040;
        vref_lvl <= 8'h20;
        pos_lvl <= 16'hff00;
        reg_wr(AC1 + 3'h1, 8'h84);
        wait_cyc(10);
        rd_chk("ref internal", AC1 + 3'h1, 8'h84);
    endtask

    task automatic test_pin();
        pos_lvl <= 16'h0080;
        reg_wr(AC1, 8'ha0);
        wait_cyc(10);
        chk("pin drive", {6'h0, pin_oe}, 8'h01);
        chk("pin level", {6'h0, pin_out}, 8'h01);
        rd_chk("result", AC1, 8'he0);
        reg_wr(AC1, 8'hb0);
        wait_cyc(10);
        chk("pin inverted", {6'h0, pin_out}, 8'h00);
        rd_chk("result inverted", AC1, 8'hb0);
        rd_chk("mirror one", ASH, 8'h02);
        dir <= 2'h1;
        wait_cyc(2);
        chk("pin released", {6'h0, pin_oe}, 8'h00);
        dir <= 2'h0;
    endtask

    task automatic flag_chk(input logic [7:0] exp, input logic irq, input logic wk);
        wait_cyc(10);
        rd_chk("flags", AFL, exp);
        chk("irq", {7'h0, irq_req}, {7'h0, irq});
        chk("wake", {7'h0, wake_req}, {7'h0, wk});
    endtask

    // comparator one runs with its pin enabled, comparator two without
    task automatic test_change();
        logic [7:0] fl;
        neg_lvl <= 32'h80808080;
        pos_lvl <= 16'h4040;
        reg_wr(AC1, 8'ha0);
        reg_wr(AC1 + 3'h1, 8'h80);
        wait_cyc(125);
        for (int i = 0; i < 2; i++) begin
            fl = 8'h0c | (8'h01 << i);
            reg_wr(AIR, 8'h03);
            rd_chk("capture", AC1 + 3'(i), (i == 0) ? 8'ha0 : 8'h80);
            reg_wr(AFL, 8'h0c);
            pos_lvl[8*i +: 8] <= 8'hc0;
            flag_chk(fl, 1'b1, 1'b1);
            rd_chk("mirror", ASH, (i == 0) ? 8'h82 : 8'h42);
            reg_wr(AFL, 8'h0c);
            flag_chk(8'h0c, 1'b0, 1'b0);
            pos_lvl[8*i +: 8] <= 8'h40;
            flag_chk(8'h0c, 1'b0, 1'b0);
            pos_lvl[8*i +: 8] <= 8'hc0;
            wait_cyc(10);
            rd_chk("recapture", AC1 + 3'(i), (i == 0) ? 8'he0 : 8'hc0);
            reg_wr(AFL, 8'h0c);
            pos_lvl[8*i +: 8] <= 8'h40;
            flag_chk(fl, 1'b1, 1'b1);
            reg_wr(AFL, 8'h0c);
            reg_wr(AC1 + 3'(i), (i == 0) ? 8'ha0 : 8'h80);
            pos_lvl[8*i +: 8] <= 8'hc0;
            reg_wr(AIR, 8'h02);
            flag_chk(fl, 1'b0, 1'b1);
            reg_wr(AIR, 8'h01);
            flag_chk(fl, 1'b0, 1'b0);
            reg_wr(AFL, 8'h08);
            reg_wr(AIR, 8'h03);
            flag_chk(8'h08, 1'b0, 1'b0);
            reg_wr(AFL, 8'h0c | (8'h01 << (1 - i)));
            flag_chk(8'h0c | (8'h01 << (1 - i)), 1'b1, 1'b1);
            reg_wr(AFL, 8'h0c);
            pos_lvl[8*i +: 8] <= 8'h40;
            wait_cyc(10);
            reg_wr(AC1 + 3'(i), (i == 0) ? 8'ha0 : 8'h80);
        end
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        test_reset();
        test_fields();
        test_channels();
        test_pin();
        test_change();
        end_of_test();
    end
endmodule

`default_nettype wire
